// [verilog/hvm_pkg.sv]
/*
  Shared constants, field positions, commands and carriers for the
  high-voltage status, monitor and wake pin block.
  Assumes a single 125 MHz clock domain.
*/
package hvm_pkg;

  // Clock rate and timing
  localparam int CLK_MHZ        = 125;
  localparam int LATENCY_US     = 10;
  localparam int LATENCY_CYCLES = LATENCY_US * CLK_MHZ;
  localparam int TIMEOUT_MS     = 1300;
  localparam int TIMEOUT_CYCLES = TIMEOUT_MS * 1000 * CLK_MHZ;
  localparam int SHORT_US       = 400;
  localparam int SHORT_CYCLES   = SHORT_US * CLK_MHZ;
  localparam int LAT_W          = 11;
  localparam int TMR_W          = 28;

  // Change-of-state status fields
  localparam int ST_PSM        = 5;
  localparam int ST_WAKE_EDGE  = 4;
  localparam int ST_THERMAL    = 3;
  localparam int ST_LIN_SHORT  = 2;
  localparam int ST_WAKE_SHORT = 0;

  // Live monitor fields
  localparam int MON_WAKE_PIN   = 7;
  localparam int MON_THERMAL    = 6;
  localparam int MON_BUFFER     = 4;
  localparam int MON_LVF        = 3;
  localparam int MON_LIN_SHORT  = 2;
  localparam int MON_WAKE_SHORT = 0;

  // Configuration and command register fields
  localparam int CFG0_THERM_KEEP  = 7;
  localparam int CFG0_WAKE_ASSERT = 4;
  localparam int CFG0_PSM_EN      = 3;
  localparam int CFG0_LVF_EN      = 2;
  localparam int CFG1_INPUT_MODE  = 4;
  localparam int CFG1_REENABLE    = 3;
  localparam int CFG1_LIN_PASSIVE = 2;
  localparam int CFG1_TIMEOUT_OFF = 1;
  localparam int CMD_BUSY         = 0;

  // Reset values
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] MON_RESET    = 8'h00;
  localparam logic [7:0] CFG0_RESET   = 8'h00;
  localparam logic [7:0] CFG1_RESET   = 8'h00;
  localparam logic [7:0] DATA_RESET   = 8'h00;
  localparam logic [7:0] CMD_RESET    = 8'h00;

  // Command codes written to the command register
  localparam logic [7:0] CMD_RD_STATUS = 8'h02;
  localparam logic [7:0] CMD_RD_MON    = 8'h04;
  localparam logic [7:0] CMD_WR_CFG0   = 8'h06;
  localparam logic [7:0] CMD_WR_CFG1   = 8'h08;

  typedef enum logic [2:0] {
    OP_NONE,
    OP_RD_STATUS,
    OP_RD_MON,
    OP_WR_CFG0,
    OP_WR_CFG1,
    OP_COPY
  } hvm_op_type;

  // Processor side writes
  typedef struct packed {
    logic       cmd_wr;
    logic [7:0] cmd_wdata;
    logic       data_wr;
    logic [7:0] data_wdata;
  } hvm_bus_type;

  // Comparator and sensor levels from the high-voltage die
  typedef struct packed {
    logic wake_overcurrent;
    logic lin_short;
    logic thermal;
    logic supply_low;
    logic dvdd_low;
    logic adc_buffer_on;
  } hvm_analog_type;

  function automatic hvm_op_type hvm_decode(input logic [7:0] code);
    case (code)
      CMD_RD_STATUS: hvm_decode = OP_RD_STATUS;
      CMD_RD_MON:    hvm_decode = OP_RD_MON;
      CMD_WR_CFG0:   hvm_decode = OP_WR_CFG0;
      CMD_WR_CFG1:   hvm_decode = OP_WR_CFG1;
      default:       hvm_decode = OP_NONE;
    endcase
  endfunction : hvm_decode

endpackage : hvm_pkg

// [verilog/hvm_sync_edge.sv]
/*
  Two-flop synchroniser with an edge detector behind it.
  Assumes the input may change at any time relative to clk.
*/
`timescale 1ns/1ps
module hvm_sync_edge (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Asynchronous level in
  input  wire logic async_in,
  // Synchronised level and one-cycle edge pulse
  output logic      level,
  output logic      edge_pulse
);

  logic meta;
  logic sync;
  logic prev;

  // Only the second flop reads the first
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta <= 1'b0;
      sync <= 1'b0;
      prev <= 1'b0;
    end else begin
      meta <= async_in;
      sync <= meta;
      prev <= sync;
    end
  end

  assign level      = sync;
  assign edge_pulse = sync ^ prev;

endmodule : hvm_sync_edge

// [verilog/hvm_hold_timer.sv]
/*
  Counts cycles while run stays high; expired is high once run has
  held for LIMIT cycles. Dropping run restarts the count.
  Assumes LIMIT fits in the counter width of the package.
*/
`timescale 1ns/1ps
module hvm_hold_timer #(
  parameter int unsigned LIMIT = 1
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Control
  input  wire logic run,
  // Result
  output logic      expired
);

  logic [hvm_pkg::TMR_W-1:0] cnt;
  logic [hvm_pkg::TMR_W-1:0] next_cnt;

  localparam logic [hvm_pkg::TMR_W-1:0] LIM = hvm_pkg::TMR_W'(LIMIT);

  always_comb begin
    next_cnt = '0;
    if (run) begin
      next_cnt = (cnt == LIM) ? cnt : cnt + 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end

  assign expired = run && (cnt == LIM);

endmodule : hvm_hold_timer

// [verilog/hvm_status_monitor.sv]
/*
  High-voltage status and monitor registers behind an indirect
  command/data pair, plus control of the wake pin driver.
  Assumes analog comparator levels are synchronous to clk, except the
  wake pin level, which is synchronised here.
*/
`timescale 1ns/1ps
module hvm_status_monitor #(
  parameter int unsigned TIMEOUT_LIMIT = hvm_pkg::TIMEOUT_CYCLES,
  parameter int unsigned SHORT_LIMIT   = hvm_pkg::SHORT_CYCLES
) (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst,
  // Processor side
  input  wire hvm_pkg::hvm_bus_type   bus,
  input  wire logic                   irq_enable,
  output logic [7:0]                  hv_command_reg,
  output logic [7:0]                  hv_read_data_reg,
  output logic                        high_voltage_irq,
  // High-voltage side
  input  wire hvm_pkg::hvm_analog_type analog,
  input  wire logic                   wake_pin_in,
  output logic                        wake_pin_out,
  output logic                        wake_pin_oe_n,
  output logic                        lin_driver_off
);

  typedef enum logic {S_IDLE, S_BUSY} hvm_state_type;

  // Engine state
  hvm_state_type           st;
  hvm_state_type           next_st;
  hvm_pkg::hvm_op_type     op;
  hvm_pkg::hvm_op_type     next_op;
  logic [hvm_pkg::LAT_W-1:0] lat_cnt;
  logic [hvm_pkg::LAT_W-1:0] next_lat_cnt;
  logic [7:0]              hv_config_reg_0;
  logic [7:0]              next_cfg0;
  logic [7:0]              hv_config_reg_1;
  logic [7:0]              next_cfg1;
  logic [7:0]              next_data;
  logic [7:0]              next_cmd;
  logic                    copy_pend;
  logic                    next_copy_pend;
  logic                    apply;
  logic                    clr_status;
  logic                    reenable;

  // Flag state
  logic [7:0] hv_change_status;
  logic [7:0] next_status;
  logic [7:0] hv_live_monitor;
  logic [7:0] next_mon;
  logic       therm_d;
  logic       lin_d;
  logic       psm_d;
  logic       lvf_en_d;
  logic       wake_dis;
  logic       next_wake_dis;
  logic       next_lin_off;
  logic       irq_pend;
  logic       next_irq_pend;
  logic       next_irq;
  logic       next_wake_out;

  // Events
  logic wake_lvl;
  logic wake_edge;
  logic timeout_hit;
  logic short_hit;
  logic psm_now;
  logic ev_psm;
  logic ev_edge;
  logic ev_therm;
  logic ev_lin;
  logic ev_short;
  logic any_ev;

  // Wake pin crossing into the clock domain
  hvm_sync_edge u_wake_sync (
    .clk        (clk),
    .rst        (rst),
    .async_in   (wake_pin_in),
    .level      (wake_lvl),
    .edge_pulse (wake_edge)
  );

  // Monoflop on the asserted driver
  hvm_hold_timer #(.LIMIT(TIMEOUT_LIMIT)) u_timeout (
    .clk     (clk),
    .rst     (rst),
    .run     (wake_pin_out &&
              !hv_config_reg_1[hvm_pkg::CFG1_TIMEOUT_OFF]),
    .expired (timeout_hit)
  );

  // Overcurrent must persist before it counts as a short
  hvm_hold_timer #(.LIMIT(SHORT_LIMIT)) u_short (
    .clk     (clk),
    .rst     (rst),
    .run     (wake_pin_out && analog.wake_overcurrent),
    .expired (short_hit)
  );

  always_comb begin
    psm_now  = analog.supply_low &&
               hv_config_reg_0[hvm_pkg::CFG0_PSM_EN];
    ev_psm   = psm_now && !psm_d;
    ev_edge  = wake_edge &&
               hv_config_reg_1[hvm_pkg::CFG1_INPUT_MODE];
    ev_therm = analog.thermal && !therm_d;
    ev_lin   = analog.lin_short && !lin_d;
    ev_short = short_hit &&
               !hv_live_monitor[hvm_pkg::MON_WAKE_SHORT];
    any_ev   = ev_psm || ev_edge || ev_therm ||
               ev_lin || ev_short;
  end

  // Indirect interface engine; every command or copy costs the serial latency, data writes load at once only in idle and when no command or copy starts
  always_comb begin
    next_st        = st;
    next_op        = op;
    next_lat_cnt   = lat_cnt;
    next_cfg0      = hv_config_reg_0;
    next_cfg1      = hv_config_reg_1;
    next_data      = hv_read_data_reg;
    next_copy_pend = copy_pend;
    apply          = 1'b0;
    clr_status     = 1'b0;
    reenable       = 1'b0;
    if (timeout_hit) begin
      next_cfg0[hvm_pkg::CFG0_WAKE_ASSERT] = 1'b0;
    end
    case (st)
      S_IDLE: begin
        if (copy_pend || any_ev) begin
          next_st        = S_BUSY;
          next_op        = hvm_pkg::OP_COPY;
          next_lat_cnt   = '0;
          next_copy_pend = 1'b0;
        end else if (bus.cmd_wr) begin
          next_st      = S_BUSY;
          next_op      = hvm_pkg::hvm_decode(bus.cmd_wdata);
          next_lat_cnt = '0;
        end else if (bus.data_wr) begin
          next_data = bus.data_wdata;
        end
      end
      S_BUSY: begin
        if (any_ev) begin
          next_copy_pend = 1'b1;
        end
        if (lat_cnt == hvm_pkg::LAT_W'(hvm_pkg::LATENCY_CYCLES - 1)) begin
          next_st = S_IDLE;
          apply   = 1'b1;
        end else begin
          next_lat_cnt = lat_cnt + 1'b1;
        end
      end
      default: begin
        next_st = S_IDLE;
      end
    endcase
    if (apply) begin
      case (op)
        hvm_pkg::OP_RD_STATUS, hvm_pkg::OP_COPY: begin
          next_data  = hv_change_status;
          clr_status = 1'b1;
        end
        hvm_pkg::OP_RD_MON: begin
          next_data = hv_live_monitor;
        end
        hvm_pkg::OP_WR_CFG0: begin
          next_cfg0 = hv_read_data_reg;
        end
        hvm_pkg::OP_WR_CFG1: begin
          next_cfg1 = hv_read_data_reg;
          next_cfg1[hvm_pkg::CFG1_REENABLE] = 1'b0;
          reenable  = hv_read_data_reg[hvm_pkg::CFG1_REENABLE];
        end
        default: begin
          next_data = hv_read_data_reg;
        end
      endcase
    end
    next_cmd = hvm_pkg::CMD_RESET;
    next_cmd[hvm_pkg::CMD_BUSY] = (next_st == S_BUSY);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st               <= S_IDLE;
      op               <= hvm_pkg::OP_NONE;
      lat_cnt          <= '0;
      hv_config_reg_0  <= hvm_pkg::CFG0_RESET;
      hv_config_reg_1  <= hvm_pkg::CFG1_RESET;
      hv_read_data_reg <= hvm_pkg::DATA_RESET;
      hv_command_reg   <= hvm_pkg::CMD_RESET;
      copy_pend        <= 1'b0;
    end else begin
      st               <= next_st;
      op               <= next_op;
      lat_cnt          <= next_lat_cnt;
      hv_config_reg_0  <= next_cfg0;
      hv_config_reg_1  <= next_cfg1;
      hv_read_data_reg <= next_data;
      hv_command_reg   <= next_cmd;
      copy_pend        <= next_copy_pend;
    end
  end

  // Flags, faults and pin drive; a set wins over a clear, except on the LVF flag, where low supply or disable wins
  always_comb begin
    next_status = hvm_pkg::STATUS_RESET;
    next_status[hvm_pkg::ST_PSM] = psm_now;
    next_status[hvm_pkg::ST_WAKE_EDGE] = ev_edge ||
      (hv_change_status[hvm_pkg::ST_WAKE_EDGE] && !clr_status);
    next_status[hvm_pkg::ST_THERMAL] = ev_therm ||
      (hv_change_status[hvm_pkg::ST_THERMAL] && !clr_status);
    next_status[hvm_pkg::ST_LIN_SHORT] = ev_lin ||
      (hv_change_status[hvm_pkg::ST_LIN_SHORT] && !clr_status);
    next_status[hvm_pkg::ST_WAKE_SHORT] = ev_short ||
      (hv_change_status[hvm_pkg::ST_WAKE_SHORT] && !clr_status);

    next_mon = hvm_pkg::MON_RESET;
    next_mon[hvm_pkg::MON_WAKE_PIN] = wake_lvl &&
      hv_config_reg_1[hvm_pkg::CFG1_INPUT_MODE];
    next_mon[hvm_pkg::MON_THERMAL] = ev_therm ||
      (hv_live_monitor[hvm_pkg::MON_THERMAL] && !reenable);
    next_mon[hvm_pkg::MON_BUFFER] = analog.adc_buffer_on;
    // Flag arms to one on enable; only low supply or disable drops it
    if (!hv_config_reg_0[hvm_pkg::CFG0_LVF_EN] || analog.dvdd_low) begin
      next_mon[hvm_pkg::MON_LVF] = 1'b0;
    end else if (!lvf_en_d) begin
      next_mon[hvm_pkg::MON_LVF] = 1'b1;
    end else begin
      next_mon[hvm_pkg::MON_LVF] = hv_live_monitor[hvm_pkg::MON_LVF];
    end
    next_mon[hvm_pkg::MON_LIN_SHORT] = ev_lin ||
      (hv_live_monitor[hvm_pkg::MON_LIN_SHORT] && !reenable);
    next_mon[hvm_pkg::MON_WAKE_SHORT] = ev_short ||
      (hv_live_monitor[hvm_pkg::MON_WAKE_SHORT] && !reenable);

    next_wake_dis = ev_short ||
      (ev_therm && !hv_config_reg_0[hvm_pkg::CFG0_THERM_KEEP]) ||
      (wake_dis && !reenable);
    next_lin_off = (ev_lin &&
      !hv_config_reg_1[hvm_pkg::CFG1_LIN_PASSIVE]) ||
      (lin_driver_off && !reenable);
    // Config register changes after the serial latency, or at once when the timeout clears the wake assert bit
    next_wake_out = next_cfg0[hvm_pkg::CFG0_WAKE_ASSERT] &&
                    !next_wake_dis;
    next_irq_pend = any_ev ||
      (irq_pend && !clr_status && !reenable);
    next_irq = next_irq_pend && irq_enable;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hv_change_status <= hvm_pkg::STATUS_RESET;
      hv_live_monitor  <= hvm_pkg::MON_RESET;
      therm_d          <= 1'b0;
      lin_d            <= 1'b0;
      psm_d            <= 1'b0;
      lvf_en_d         <= 1'b0;
      wake_dis         <= 1'b0;
      lin_driver_off   <= 1'b0;
      irq_pend         <= 1'b0;
      high_voltage_irq <= 1'b0;
      wake_pin_out     <= 1'b0;
      wake_pin_oe_n    <= 1'b1;
    end else begin
      hv_change_status <= next_status;
      hv_live_monitor  <= next_mon;
      therm_d          <= analog.thermal;
      lin_d            <= analog.lin_short;
      psm_d            <= psm_now;
      lvf_en_d         <= hv_config_reg_0[hvm_pkg::CFG0_LVF_EN];
      wake_dis         <= next_wake_dis;
      lin_driver_off   <= next_lin_off;
      irq_pend         <= next_irq_pend;
      high_voltage_irq <= next_irq;
      wake_pin_out     <= next_wake_out;
      wake_pin_oe_n    <= !next_wake_out;
    end
  end

endmodule : hvm_status_monitor

// [verif/hvm_status_monitor_properties.sv]
/*
  Concurrent checks on the ports of the status and monitor block.
  Assumes one clock domain with an async active-high reset; bound
  from the testbench top file.
*/
`timescale 1ns/1ps
module hvm_properties (
  // Clock and reset
  input wire logic                    clk,
  input wire logic                    rst,
  // Processor side
  input wire hvm_pkg::hvm_bus_type    bus,
  input wire logic                    irq_enable,
  input wire logic [7:0]              hv_command_reg,
  input wire logic [7:0]              hv_read_data_reg,
  input wire logic                    high_voltage_irq,
  // High-voltage side
  input wire hvm_pkg::hvm_analog_type analog,
  input wire logic                    wake_pin_out,
  input wire logic                    wake_pin_oe_n,
  input wire logic                    lin_driver_off
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Counter, since 1250 cycles is too long for a repetition
  logic [10:0] busy_run;
  logic [10:0] next_busy_run;
  always_comb next_busy_run = hv_command_reg[0] ? busy_run + 11'h001 : 11'h000;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) busy_run <= 11'h000;
    else busy_run <= next_busy_run;
  end

  sequence s_copy_start;
    high_voltage_irq && hv_command_reg[0];
  endsequence

  a_oe_inverse: assert property (wake_pin_oe_n == !wake_pin_out)
    else $error("wake enable not inverse of drive");
  a_cmd_reserved: assert property (hv_command_reg[7:1] == 7'h00)
    else $error("command register upper bits set");
  a_busy_length: assert property ($fell(hv_command_reg[0])
    |-> busy_run == 11'(hvm_pkg::LATENCY_CYCLES))
    else $error("busy length wrong");
  a_busy_bound: assert property (busy_run <= 11'h4E2)
    else $error("busy held too long");
  // An event on the last busy edge queues its copy one cycle later
  a_irq_gated: assert property ($rose(high_voltage_irq)
    |-> $past(irq_enable) ##1 hv_command_reg[0])
    else $error("interrupt without enable or copy");
  a_thermal_copy: assert property ($rose(analog.thermal)
    && !hv_command_reg[0] && irq_enable |-> ##[1:2] s_copy_start)
    else $error("thermal event did not start copy");
  a_lin_cut: assert property ($rose(analog.lin_short)
    |-> ##[1:2] lin_driver_off)
    else $error("LIN driver not disabled");
  a_wake_latency: assert property ($rose(wake_pin_out)
    |-> $fell(hv_command_reg[0]))
    else $error("wake drive changed off transfer end");
  a_data_loads: assert property ($changed(hv_read_data_reg)
    |-> $fell(hv_command_reg[0]) || $past(bus.data_wr))
    else $error("data register changed unexpectedly");
endmodule : hvm_properties

// [verif/hvm_wake_bus.sv]
/*
  External wake bus: pull-down, another node able to pull it high,
  and a load that can short the driven pin to ground.
  Assumes the bench steers ext_high and shorted.
*/
`timescale 1ns/1ps
module hvm_wake_bus (
  // Device pin
  input  wire logic wake_pin_out,
  input  wire logic wake_pin_oe_n,
  output logic      wake_pin_in,
  output logic      overcurrent,
  // Bench control
  input  wire logic ext_high,
  input  wire logic shorted
);
  // Wired-OR with pull-down, so a released bus reads low
  assign wake_pin_in = (!wake_pin_oe_n && wake_pin_out) || ext_high;
  assign overcurrent = shorted && !wake_pin_oe_n && wake_pin_out;
endmodule : hvm_wake_bus

// [verif/hvm_status_monitor_test.sv]
/*
  Self-checking bench for the status monitor and wake pin control.
  Assumes the package and design under verilog/ are compiled first.
*/
`timescale 1ns/1ps
module hvm_status_monitor_test;
  localparam int TL = 50;
  localparam int SL = 20;
  logic                    clk = 1'b0;
  logic                    rst = 1'b1;
  hvm_pkg::hvm_bus_type    bus = '0;
  hvm_pkg::hvm_analog_type an  = '0;
  hvm_pkg::hvm_analog_type ana;
  logic                    irq_en = 1'b1;
  logic                    ext_high = 1'b0;
  logic                    shorted = 1'b0;
  logic                    prev_busy = 1'b0;
  logic [7:0]              cmd_q, data_q, mon;
  logic                    irq, w_in, w_out, w_oe_n, lin_off, oc;
  logic [7:0]              notes[$];
  int                      mismatches = 0;
  int                      checked = 0;

  always #4 clk = ~clk;
  assign ana = {oc, an[4:0]};

  hvm_status_monitor #(.TIMEOUT_LIMIT(TL), .SHORT_LIMIT(SL)) dut (
    .clk(clk), .rst(rst), .bus(bus), .irq_enable(irq_en),
    .hv_command_reg(cmd_q), .hv_read_data_reg(data_q),
    .high_voltage_irq(irq), .analog(ana), .wake_pin_in(w_in),
    .wake_pin_out(w_out), .wake_pin_oe_n(w_oe_n), .lin_driver_off(lin_off));
  hvm_wake_bus far_side (.wake_pin_out(w_out), .wake_pin_oe_n(w_oe_n),
    .wake_pin_in(w_in), .overcurrent(oc), .ext_high(ext_high),
    .shorted(shorted));

  task automatic test_done;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  // Each finished transfer settles the oldest note
  always @(negedge clk) begin
    if (prev_busy && cmd_q[0] === 1'b0) begin
      if (notes.size() == 0) begin
        mismatches++;
        $display("unexpected at %0t: result with no note", $time);
      end else begin
        chk(data_q, notes.pop_front());
      end
    end
    prev_busy = cmd_q[0];
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  // Bounded wait for busy to rise and then fall
  task automatic done;
    int i;
    i = 0;
    while (cmd_q[0] !== 1'b1 && i < 100) begin
      tick(1);
      i++;
    end
    if (i == 100) begin
      mismatches++;
      $display("unexpected at %0t: busy never rose", $time);
    end
    i = 0;
    while (cmd_q[0] !== 1'b0 && i < 1400) begin
      tick(1);
      i++;
    end
    if (i == 1400) begin
      mismatches++;
      $display("unexpected at %0t: busy stuck", $time);
    end
  endtask : done

  task automatic op(input logic [7:0] code, input logic [7:0] exp);
    notes.push_back(exp);
    bus.cmd_wr = 1'b1;
    bus.cmd_wdata = code;
    tick(1);
    bus.cmd_wr = 1'b0;
    done();
  endtask : op

  // Operand first, command on the next edge
  task automatic cfg(input logic [7:0] code, input logic [7:0] val);
    bus.data_wr = 1'b1;
    bus.data_wdata = val;
    tick(1);
    bus.data_wr = 1'b0;
    op(code, val);
  endtask : cfg

  task automatic evt(input logic [7:0] exp);
    notes.push_back(exp);
    done();
  endtask : evt

  initial begin
    tick(60000);
    mismatches++;
    test_done();
  end

  initial begin
    void'($urandom(32'hB57C9CEC));
    an.adc_buffer_on = 1'($urandom_range(0, 1));
    mon = {3'h0, an.adc_buffer_on, 4'h0};
    tick(20);
    rst = 1'b0;
    chk(cmd_q, 8'h00);
    chk({4'h0, irq, w_out, w_oe_n, lin_off}, 8'h02);
    op(hvm_pkg::CMD_RD_STATUS, 8'h00);
    op(hvm_pkg::CMD_RD_MON, mon);
    op(8'(2 * $urandom_range(0, 127) + 1), mon);
    an.thermal = 1'b1;
    tick(2);
    chk({7'h00, irq}, 8'h01);
    evt(8'h08);
    op(hvm_pkg::CMD_RD_MON, mon | 8'h40);
    // Thermal event has shut the driver until re-enable
    cfg(hvm_pkg::CMD_WR_CFG0, 8'h10);
    chk({7'h00, w_out}, 8'h00);
    an.thermal = 1'b0;
    cfg(hvm_pkg::CMD_WR_CFG1, 8'h08);
    cfg(hvm_pkg::CMD_WR_CFG0, 8'h10);
    chk({7'h00, w_out}, 8'h01);
    tick(TL - 5);
    chk({7'h00, w_out}, 8'h01);
    tick(10);
    chk({7'h00, w_out}, 8'h00);
    // Keep bit set: thermal must leave the driver on
    cfg(hvm_pkg::CMD_WR_CFG0, 8'h90);
    an.thermal = 1'b1;
    tick(2);
    chk({7'h00, w_out}, 8'h01);
    evt(8'h08);
    an.thermal = 1'b0;
    cfg(hvm_pkg::CMD_WR_CFG1, 8'h0A);
    cfg(hvm_pkg::CMD_WR_CFG0, 8'h10);
    tick(TL + 20);
    chk({7'h00, w_out}, 8'h01);
    cfg(hvm_pkg::CMD_WR_CFG0, 8'h00);
    chk({7'h00, w_out}, 8'h00);
    shorted = 1'b1;
    cfg(hvm_pkg::CMD_WR_CFG0, 8'h10);
    evt(8'h01);
    op(hvm_pkg::CMD_RD_MON, mon | 8'h01);
    shorted = 1'b0;
    cfg(hvm_pkg::CMD_WR_CFG0, 8'h00);
    cfg(hvm_pkg::CMD_WR_CFG1, 8'h08);
    an.lin_short = 1'b1;
    tick(2);
    chk({7'h00, lin_off}, 8'h01);
    evt(8'h04);
    op(hvm_pkg::CMD_RD_MON, mon | 8'h04);
    an.lin_short = 1'b0;
    cfg(hvm_pkg::CMD_WR_CFG1, 8'h08);
    chk({7'h00, lin_off}, 8'h00);
    op(hvm_pkg::CMD_RD_MON, mon);
    cfg(hvm_pkg::CMD_WR_CFG0, 8'h08);
    an.supply_low = 1'b1;
    evt(8'h20);
    an.supply_low = 1'b0;
    op(hvm_pkg::CMD_RD_STATUS, 8'h00);
    cfg(hvm_pkg::CMD_WR_CFG0, 8'h04);
    op(hvm_pkg::CMD_RD_MON, mon | 8'h08);
    an.dvdd_low = 1'b1;
    tick(2);
    an.dvdd_low = 1'b0;
    op(hvm_pkg::CMD_RD_MON, mon);
    irq_en = 1'b0;
    cfg(hvm_pkg::CMD_WR_CFG1, 8'h10);
    ext_high = 1'b1;
    tick(6);
    chk({7'h00, irq}, 8'h00);
    evt(8'h10);
    op(hvm_pkg::CMD_RD_MON, mon | 8'h80);
    ext_high = 1'b0;
    evt(8'h10);
    tick(10);
    chk(cmd_q, 8'h00);
    if (notes.size() != 0) begin
      mismatches++;
      $display("unexpected at %0t: %0d results missing", $time, notes.size());
    end
    test_done();
  end
endmodule : hvm_status_monitor_test

bind hvm_status_monitor hvm_properties props (.clk(clk), .rst(rst),
  .bus(bus), .irq_enable(irq_enable), .hv_command_reg(hv_command_reg),
  .hv_read_data_reg(hv_read_data_reg), .high_voltage_irq(high_voltage_irq),
  .analog(analog), .wake_pin_out(wake_pin_out),
  .wake_pin_oe_n(wake_pin_oe_n), .lin_driver_off(lin_driver_off));
